// File: bench/reg_host.sv
// register host model: issues single byte reads and writes on the request port
`timescale 1ns/1ps
module reg_host
  import timebase_pkg::*;
(
  // clock
  input wire logic clk,
  // request port
  output reg_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial req = '0;
  // strobe is held for one edge only, so two requests never merge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    q = 8'hxx;
    @(posedge clk);
    req <= '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge clk);
    req <= '0;
    // bounded wait; a missing answer leaves q unknown and fails the compare
    for (int i = 0; i < 4 && !w; i++)
    begin
      #1;
      if (rvalid === 1'b1)
      begin
        q = rdata; // taken in the cycle the answer stands
        break;
      end
      @(posedge clk);
    end
  endtask
endmodule

// File: bench/test_timebase_divider_and_data_format.sv
// testbench: byte format of wide values, divider register, tick period, N factor
`timescale 1ns/1ps
module test_timebase_divider_and_data_format;
  import timebase_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic ext = 0;
  logic int_osc = 0;
  logic ce = 1;
  logic [6:0] cfg = 7'h06;
  meas_s meas = '{12'habc, 24'h123456, 32'h89abcdef, 32'h01020304, 32'hf0e0d0c0};
  reg_req_s req;
  logic [7:0] rdata, q;
  logic rvalid, tick;
  logic [4:0] div;
  logic [25:0] nf;
  int n_fail = 0, samples_checked = 0, t, p;
  // address beside expected byte; unmapped 0x50 reads zero
  logic [15:0] rows [19] = '{16'h00ab, 16'h01c0, 16'h0212, 16'h0334, 16'h0456,
    16'h0589, 16'h06ab, 16'h07cd, 16'h08ef, 16'h0901, 16'h0a02, 16'h0b03, 16'h0c04,
    16'h0df0, 16'h0ee0, 16'h0fd0, 16'h10c0, 16'h4304, 16'h5000};
  always #2 clk = ~clk;
  // external clock of eight system cycles, edges on falling clk edges, away from rising clk edges
  always #16 ext = ~ext;
  timebase_core u_dut (.clk(clk), .rst(rst), .ce(ce), .external_clock_input(ext),
    .use_internal_osc(int_osc), .converter_config_bits(cfg), .req(req),
    .rdata(rdata), .rvalid(rvalid), .meas(meas), .sys_tick(tick),
    .divider_bits(div), .n_factor_x10k(nf));
  reg_host u_host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // cycles from one tick to the next; a lost tick ends the run
  task automatic period();
    for (p = 0; p < 3000 && tick !== 1'b1; p++)
      @(posedge clk) #1;
    for (p = 1; p < 3000; p++)
    begin
      @(posedge clk) #1;
      if (tick === 1'b1)
        break;
    end
    if (p >= 3000)
    begin
      n_fail++;
      conclude();
    end
  endtask
  // one N table row: set the config, let the registered factor settle, compare
  task automatic ncase(input logic [6:0] c, input logic [25:0] e);
    @(posedge clk) cfg <= c;
    repeat (3) @(posedge clk) #1;
    chk("n factor", e, nf);
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 0;
    chk("divider reset", 5'h04, div);
    chk("rvalid in reset", 1'b0, rvalid);
    chk("rdata in reset", 8'h00, rdata);
    for (t = 0; t < 19; t++)
    begin
      u_host.xfer(0, rows[t][15:8], 8'h00, q);
      chk("read byte", rows[t][7:0], q);
    end
    $display("test rows done");
    // reserved bits of the divider stay zero; measurement bytes ignore writes
    u_host.xfer(1, div_offset, 8'hff, q);
    u_host.xfer(1, 8'h00, 8'h55, q);
    u_host.xfer(0, div_offset, 8'h00, q);
    chk("divider read", 8'h1f, q);
    chk("divider port", 5'h1f, div);
    u_host.xfer(0, 8'h00, 8'h00, q);
    chk("adc high", 8'hab, q);
    $display("test divider register done");
    // divider 2 with an 8-cycle external clock gives 4*2*8 cycles a tick
    u_host.xfer(1, div_offset, 8'h02, q);
    period();
    period();
    chk("external tick", 64, p);
    @(posedge clk) int_osc <= 1;
    period();
    period();
    chk("internal tick", internal_tick_cycles, p);
    $display("test tick period done");
    // fixed code wins over the other field, then the full-rate example
    @(posedge clk) cfg <= 7'h66;
    repeat (3) @(posedge clk) #1;
    chk("n fixed", 26'd40985000, nf);
    @(posedge clk) cfg <= 7'h63;
    repeat (3) @(posedge clk) #1;
    chk("n example", 26'd40997500, nf);
    ncase(7'h00, 26'd40988571);
    ncase(7'h45, 26'd40985097);
    ncase(7'h2b, 26'd40996429);
    ncase(7'h5c, 26'd40985800);
    $display("test n factor done");
    // clock enable low freezes the divider, so a write in that time is lost
    @(posedge clk) ce <= 0;
    u_host.xfer(1, div_offset, 8'h09, q);
    chk("frozen divider", 5'h02, div);
    @(posedge clk) ce <= 1;
    $display("test clock enable done");
    // second reset in mid-run restores the divider and clears the read port
    @(posedge clk) rst <= 1;
    repeat (2) @(posedge clk) #1;
    chk("divider rereset", 5'h04, div);
    chk("rvalid rereset", 1'b0, rvalid);
    chk("rdata rereset", 8'h00, rdata);
    @(posedge clk) rst <= 0;
    u_host.xfer(0, div_offset, 8'h00, q);
    chk("divider after rereset", 8'h04, q);
    $display("test reset done");
    conclude();
  end
endmodule

// File: rtl/tick_divider.sv
// tick generator: divides the external clock by four times the divider field
`timescale 1ns/1ps
module tick_divider
#(
  parameter int width = 5
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic [width-1:0] divider_bits,
  input wire logic ext_edge,
  // output
  output logic tick
);
  import timebase_pkg::*;

  typedef struct packed
  {
    logic [width+1:0] cnt;
    logic tick;
  } st_s;

  st_s st;
  st_s next_st;
  logic [width+1:0] limit;

  // divide by 4*divider; a zero field is treated as one so the tick never stalls
  assign limit = (divider_bits == '0) ? (width+2)'(4) : {divider_bits, 2'b00};

  // count external edges, pulse once per full period
  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (ext_edge)
    begin
      if (st.cnt >= limit - (width+2)'(1))
      begin
        next_st.cnt = '0;
        next_st.tick = 1'b1;
      end
      else
        next_st.cnt = st.cnt + (width+2)'(1);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign tick = st.tick;

  // ==========================================================================
  // checks
  a_tick_width: assert property (@(posedge clk) disable iff (rst || !ce)
    st.tick |=> !st.tick)
    else $error("divider tick longer than one cycle");
endmodule

// File: rtl/timebase_core.sv
// top: timebase divider register, tick generation and byte-wise data format
`timescale 1ns/1ps
module timebase_core
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // time base source
  input wire logic external_clock_input,
  input wire logic use_internal_osc,
  input wire logic [6:0] converter_config_bits,
  // register access
  input wire timebase_pkg::reg_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  // measurement values from the converter path
  input wire timebase_pkg::meas_s meas,
  // status
  output logic sys_tick,
  output logic [4:0] divider_bits,
  output logic [25:0] n_factor_x10k
);
  import timebase_pkg::*;

  typedef struct packed
  {
    logic [4:0] div;
    logic [2:0] sync;
    logic prev;
    logic [9:0] osc_cnt;
    logic osc_tick;
    logic [7:0] rdata;
    logic rvalid;
    logic [25:0] nf;
  } st_s;

  st_s st;
  st_s next_st;
  logic ext_edge;
  logic div_tick;

  // ==========================================================================
  // helpers
  // pick the byte of a wide value, most significant at the base address
  function automatic logic [7:0] pick_byte(input logic [31:0] v, input int nbytes,
                                           input int idx);
    pick_byte = v[8*(nbytes-1-idx) +: 8];
  endfunction

  // N lookup, scaled by 10000; code 110 wins whatever the upper field holds,
  // and 111, which has no entry, falls back to the same fixed value
  function automatic logic [25:0] n_lookup(input logic [1:0] hi, input logic [2:0] lo);
    if (lo == chan_fixed_code)
      n_lookup = n_fixed_x10k;
    else
    begin
      case ({hi, lo})
        5'h1b: n_lookup = n_full_x10k;
        5'h1a, 5'h1d: n_lookup = n_11_c25_x10k;
        5'h19, 5'h1c: n_lookup = n_11_c14_x10k;
        5'h18: n_lookup = n_11_c0_x10k;
        5'h13: n_lookup = n_10_c3_x10k;
        5'h12, 5'h15: n_lookup = n_10_c25_x10k;
        5'h11, 5'h14: n_lookup = n_10_c14_x10k;
        5'h10: n_lookup = n_10_c0_x10k;
        5'h0b: n_lookup = n_01_c3_x10k;
        5'h0a, 5'h0d: n_lookup = n_01_c25_x10k;
        5'h09, 5'h0c: n_lookup = n_01_c14_x10k;
        5'h08: n_lookup = n_01_c0_x10k;
        5'h03: n_lookup = n_00_c3_x10k;
        5'h02, 5'h05: n_lookup = n_00_c25_x10k;
        5'h01, 5'h04: n_lookup = n_00_c14_x10k;
        5'h00: n_lookup = n_00_c0_x10k;
        default: n_lookup = n_fixed_x10k; // code 111 has no entry
      endcase
    end
  endfunction

  // three-stage synchroniser: the accepted level moves only once stages two and
  // three agree, and an edge is a rise of that accepted level
  assign ext_edge = (st.sync[1] == st.sync[2]) && st.sync[2] && !st.prev;

  tick_divider #(.width(div_width)) u_div
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .divider_bits(st.div),
    .ext_edge(ext_edge),
    .tick(div_tick)
  );

  // ==========================================================================
  // state update
  // register write, read mux, internal oscillator tick and N tracking
  always_comb
  begin
    next_st = st;
    next_st.sync = {st.sync[1:0], external_clock_input};
    // accepted level follows the pin once the last two stages agree, so a
    // metastable first stage can never count as an edge of its own
    if (st.sync[1] == st.sync[2])
      next_st.prev = st.sync[2];
    next_st.rvalid = 1'b0;
    next_st.osc_tick = 1'b0;
    if (st.osc_cnt == 10'(internal_tick_cycles - 1))
    begin
      next_st.osc_cnt = '0;
      next_st.osc_tick = 1'b1;
    end
    else
      next_st.osc_cnt = st.osc_cnt + 10'h001;
    next_st.nf = n_lookup(converter_config_bits[6:5], converter_config_bits[2:0]);
    if (req.wr && req.addr == div_offset)
      next_st.div = req.wdata[div_width-1:0];
    if (req.rd)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = 8'h00;
      if (req.addr == div_offset)
        next_st.rdata = {div_reserved_value, st.div};
      else if (req.addr == adc_base)
        next_st.rdata = meas.adc[11:4];
      else if (req.addr == adc_base + 8'h01)
        next_st.rdata = {meas.adc[3:0], 4'h0};
      else if (req.addr >= power_base && req.addr < time_base)
        next_st.rdata = pick_byte({8'h00, meas.power}, 3, int'(req.addr - power_base));
      else if (req.addr >= time_base && req.addr < charge_base)
        next_st.rdata = pick_byte(meas.timer, 4, int'(req.addr - time_base));
      else if (req.addr >= charge_base && req.addr < energy_base)
        next_st.rdata = pick_byte(meas.charge, 4, int'(req.addr - charge_base));
      else if (req.addr >= energy_base && req.addr < energy_base + 8'h04)
        next_st.rdata = pick_byte(meas.energy, 4, int'(req.addr - energy_base));
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.div <= div_reset[4:0];
      st.nf <= n_fixed_x10k;
    end
    else if (ce)
      st <= next_st;
  end

  // ==========================================================================
  // outputs
  // timer count source: internal oscillator or divided external clock
  assign sys_tick = use_internal_osc ? st.osc_tick : div_tick;
  assign rdata = st.rdata;
  assign rvalid = st.rvalid;
  assign divider_bits = st.div;
  assign n_factor_x10k = st.nf;

  // ==========================================================================
  // checks
  a_div_reset: assert property (@(posedge clk) $fell(rst) |-> st.div == 5'h04)
    else $error("divider not at reset value");
  a_div_write: assert property (@(posedge clk) disable iff (rst)
    ce && req.wr && req.addr == div_offset |=> st.div == $past(req.wdata[4:0]))
    else $error("divider write lost");
  a_div_read: assert property (@(posedge clk) disable iff (rst)
    ce && req.rd && req.addr == div_offset |=> rdata[7:5] == 3'h0 && rdata[4:0] == $past(st.div))
    else $error("divider readback wrong");
  a_adc_low: assert property (@(posedge clk) disable iff (rst)
    ce && req.rd && req.addr == 8'h01 |=> rdata == {$past(meas.adc[3:0]), 4'h0})
    else $error("adc low byte wrong");
  a_adc_high: assert property (@(posedge clk) disable iff (rst)
    ce && req.rd && req.addr == 8'h00 |=> rdata == $past(meas.adc[11:4]))
    else $error("adc high byte wrong");
  a_power_msb: assert property (@(posedge clk) disable iff (rst)
    ce && req.rd && req.addr == 8'h02 |=> rdata == $past(meas.power[23:16]))
    else $error("power msb wrong");
  a_power_lsb: assert property (@(posedge clk) disable iff (rst)
    ce && req.rd && req.addr == 8'h04 |=> rdata == $past(meas.power[7:0]))
    else $error("power lsb wrong");
  a_time_msb: assert property (@(posedge clk) disable iff (rst)
    ce && req.rd && req.addr == 8'h05 |=> rdata == $past(meas.timer[31:24]))
    else $error("timer msb wrong");
  a_time_lsb: assert property (@(posedge clk) disable iff (rst)
    ce && req.rd && req.addr == 8'h08 |=> rdata == $past(meas.timer[7:0]))
    else $error("timer lsb wrong");
  a_charge_msb: assert property (@(posedge clk) disable iff (rst)
    ce && req.rd && req.addr == 8'h09 |=> rdata == $past(meas.charge[31:24]))
    else $error("charge msb wrong");
  a_energy_msb: assert property (@(posedge clk) disable iff (rst)
    ce && req.rd && req.addr == 8'h0d |=> rdata == $past(meas.energy[31:24]))
    else $error("energy msb wrong");
  a_energy_lsb: assert property (@(posedge clk) disable iff (rst)
    ce && req.rd && req.addr == 8'h10 |=> rdata == $past(meas.energy[7:0]))
    else $error("energy lsb wrong");
  a_read_answer: assert property (@(posedge clk) disable iff (rst)
    ce |=> rvalid == $past(req.rd))
    else $error("read answer not one cycle after the request");
  a_read_hold: assert property (@(posedge clk) disable iff (rst)
    ce && !req.rd |=> $stable(rdata))
    else $error("read data changed without a read");
  a_ce_freeze: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(st))
    else $error("state moved while clock enable low");
  a_n_fixed: assert property (@(posedge clk) disable iff (rst)
    ce && converter_config_bits[2:0] == 3'h6 |=> n_factor_x10k == 26'd40985000)
    else $error("N for code 110 wrong");
  a_n_full: assert property (@(posedge clk) disable iff (rst)
    ce && converter_config_bits[6:5] == 2'h3 && converter_config_bits[2:0] == 3'h3
    |=> n_factor_x10k == 26'd40997500)
    else $error("N for code 11 011 wrong");
  a_n_low_row: assert property (@(posedge clk) disable iff (rst)
    ce && converter_config_bits[6:5] == 2'h0 && converter_config_bits[2:0] == 3'h0
    |=> n_factor_x10k == 26'd40988571)
    else $error("N for code 00 000 wrong");
  a_n_mid_row: assert property (@(posedge clk) disable iff (rst)
    ce && converter_config_bits[6:5] == 2'h2 && converter_config_bits[2:0] == 3'h5
    |=> n_factor_x10k == 26'd40985097)
    else $error("N for code 10 101 wrong");
  a_osc_period: assert property (@(posedge clk) disable iff (rst || !ce)
    st.osc_tick |=> (!st.osc_tick)[*8])
    else $error("oscillator tick longer than one cycle");
  // covers of the main scenarios
  c_div_write: cover property (@(posedge clk) req.wr && req.addr == div_offset);
  c_ext_tick: cover property (@(posedge clk) !use_internal_osc && sys_tick);
  c_int_tick: cover property (@(posedge clk) use_internal_osc && sys_tick);
  c_ce_freeze: cover property (@(posedge clk) !ce && req.wr);
  c_rerelease: cover property (@(posedge clk) $fell(rst));
endmodule

// File: rtl/timebase_pkg.sv
// package: register map, data formats and timing constants of the timebase block
// ==========================================================================
// What this block does
// - system tick = external clock divided by four times the divider field, aims 250kHz.
// - divider register bits 4..0 read/write, reset 00100b; bits 7..5 read zero.
// - 12-bit value: high byte bits 11..4, low byte bits 3..0 then four zeros.
// - 24-bit power values split into three bytes, bits 23..16, 15..8, 7..0.
// - 32-bit time, charge, energy as four bytes, bits 31..24 down to 7..0.
// - one timer count is N times four-times-divider over external clock, or N*4us.
// - N follows converter config; channel code 110 always gives 4098.5.
package timebase_pkg;
  localparam logic [7:0] div_offset = 8'h43;
  localparam logic [7:0] div_reset = 8'h04;
  localparam int div_lsb = 0;
  localparam int div_width = 5;
  localparam logic [2:0] div_reserved_value = 3'h0;
  localparam int sys_tick_khz = 250;
  localparam int internal_tick_ns = 4000;
  localparam int clk_period_ns = 4;
  // internal oscillator tick in fast-clock cycles
  localparam int internal_tick_cycles = internal_tick_ns / clk_period_ns;
  // map of the wide values, base address of the most significant byte
  localparam logic [7:0] adc_base = 8'h00;
  localparam logic [7:0] power_base = 8'h02;
  localparam logic [7:0] time_base = 8'h05;
  localparam logic [7:0] charge_base = 8'h09;
  localparam logic [7:0] energy_base = 8'h0d;
  localparam logic [2:0] chan_fixed_code = 3'h6;
  // N scaled by 10000: the fixed-code value, then one group per upper field value;
  // column c3 is code 011, c25 codes 010/101, c14 codes 001/100, c0 code 000
  localparam logic [25:0] n_fixed_x10k = 26'd40985000;
  localparam logic [25:0] n_full_x10k = 26'd40997500;
  localparam logic [25:0] n_11_c25_x10k = 26'd40985098;
  localparam logic [25:0] n_11_c14_x10k = 26'd40985806;
  localparam logic [25:0] n_11_c0_x10k = 26'd40993333;
  localparam logic [25:0] n_10_c3_x10k = 26'd40997355;
  localparam logic [25:0] n_10_c25_x10k = 26'd40985097;
  localparam logic [25:0] n_10_c14_x10k = 26'd40985800;
  localparam logic [25:0] n_10_c0_x10k = 26'd40993549;
  localparam logic [25:0] n_01_c3_x10k = 26'd40996429;
  localparam logic [25:0] n_01_c25_x10k = 26'd40985092;
  localparam logic [25:0] n_01_c14_x10k = 26'd40985758;
  localparam logic [25:0] n_01_c0_x10k = 26'd40992692;
  localparam logic [25:0] n_00_c3_x10k = 26'd40990000;
  localparam logic [25:0] n_00_c25_x10k = 26'd40985049;
  localparam logic [25:0] n_00_c14_x10k = 26'd40985397;
  localparam logic [25:0] n_00_c0_x10k = 26'd40988571;

  typedef struct packed
  {
    logic [11:0] adc;
    logic [23:0] power;
    logic [31:0] timer;
    logic [31:0] charge;
    logic [31:0] energy;
  } meas_s;

  typedef struct packed
  {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_s;
endpackage
